// [tmr_params.svh]
`ifndef TMR_PARAMS_SVH
`define TMR_PARAMS_SVH

// ==========================================================
// Register map (register index, byte address is index times four)
`define TMR_CSR_INDEX      6'h08
`define TMR_CNT_INDEX      6'h09
`define TMR_ADDR_W         8

// ==========================================================
// Control and status field positions
`define TMR_BIT_RATE_LO    0
`define TMR_BIT_RATE_HI    1
`define TMR_BIT_TICK_ACK   2
`define TMR_BIT_WRAP_ACK   3
`define TMR_BIT_TICK_EN    4
`define TMR_BIT_WRAP_EN    5
`define TMR_BIT_TICK_FLAG  6
`define TMR_BIT_WRAP_FLAG  7

// ==========================================================
// Reset values
`define TMR_RATE_RESET     2'h3
`define TMR_EN_RESET       1'h0
`define TMR_FLAG_RESET     1'h0

// ==========================================================
// Chain geometry and power-on timing
`define TMR_PRESC_BITS     2
`define TMR_COUNT_BITS     8
`define TMR_TICK_BASE      13
`define TMR_POR_CYCLES     4064
`define TMR_POR_CNT_W      12

`endif

// [tmr_pkg.sv]
package tmr_pkg;

    // ======================================================
    // Reset sequencer states
    typedef enum logic [1:0] {
        tmr_por_count,
        tmr_ext_hold,
        tmr_running
    } tmr_seq_e;

    typedef logic [1:0] tmr_rate_t;

endpackage

// [tmr_chain_if.sv]
`timescale 1ns/1ps

interface tmr_chain_if #(parameter int COUNT_W = 8);
    logic                clear;
    logic                run;
    logic [1:0]          rate_sel;
    logic [COUNT_W-1:0]  count;
    logic                wrap_evt;
    logic                tick_evt;

    modport chain (input clear, input run, input rate_sel,
                   output count, output wrap_evt, output tick_evt);
    modport ctrl  (output clear, output run, output rate_sel,
                   input count, input wrap_evt, input tick_evt);
endinterface

// [tmr_chain.sv]
`timescale 1ns/1ps
`include "tmr_params.svh"

module tmr_chain
    import tmr_pkg::*;
#(
    parameter int PRESC_W   = `TMR_PRESC_BITS,
    parameter int COUNT_W   = `TMR_COUNT_BITS,
    parameter int TICK_BASE = `TMR_TICK_BASE
) (
    input  wire logic    i_clock,
    input  wire logic    i_rst,
    tmr_chain_if.chain   u_if
);

    localparam int TOTAL_W = TICK_BASE + 4;
    localparam int WRAP_W  = PRESC_W + COUNT_W;

    generate
        if (WRAP_W > TICK_BASE || PRESC_W < 1 || COUNT_W < 1) begin : g_bad
            $error("tmr_chain: chain geometry cannot hold the tick taps");
        end
    endgenerate

    logic [TOTAL_W-1:0] chain_ff;
    logic               tap_prev_ff;
    logic               wrap_evt_ff;
    logic               tick_evt_ff;

    // ======================================================
    // Tap selection
    function automatic logic tap_pick(input logic [TOTAL_W-1:0] v, input tmr_rate_t sel);
        logic r;
        r = v[TICK_BASE + int'(sel)];
        return r;
    endfunction

    wire                clr_now  = i_rst | u_if.clear;
    wire                carry    = &chain_ff[WRAP_W-1:0];
    wire                tap_now  = tap_pick(chain_ff, u_if.rate_sel);
    wire [TOTAL_W-1:0]  nxt_chain = chain_ff + {{(TOTAL_W-1){1'b0}}, 1'b1};

    assign u_if.count    = chain_ff[PRESC_W +: COUNT_W];
    assign u_if.wrap_evt = wrap_evt_ff;
    assign u_if.tick_evt = tick_evt_ff;

    // ======================================================
    // Divider chain: prescaler, counter, tick stages
    always_ff @(posedge i_clock) begin
        if (clr_now) begin
            chain_ff    <= '0;
            tap_prev_ff <= 1'b0;
            wrap_evt_ff <= 1'b0;
            tick_evt_ff <= 1'b0;
        end else if (u_if.run) begin
            chain_ff    <= nxt_chain;
            tap_prev_ff <= tap_now;
            wrap_evt_ff <= carry;
            tick_evt_ff <= tap_now & ~tap_prev_ff;
        end else begin
            // Stopped: chain frozen, no events
            wrap_evt_ff <= 1'b0;
            tick_evt_ff <= 1'b0;
        end
    end

endmodule

// [tmr_top.sv]
`timescale 1ns/1ps
`include "tmr_params.svh"


module tmr_top
    import tmr_pkg::*;
#(
    parameter int COUNT_W = `TMR_COUNT_BITS
) (
    input  wire logic        i_clock,
    input  wire logic        i_rst,
    input  wire logic        i_ext_reset,
    input  wire logic        i_stop_mode,
    input  wire logic [7:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    input  wire logic [3:0]  i_avs_byteenable,
    output logic      [31:0] o_avs_readdata,
    output logic             o_avs_waitrequest,
    output logic             o_irq,
    output logic             o_por_busy
);

    generate
        if (COUNT_W != `TMR_COUNT_BITS) begin : g_bad
            $error("tmr_top: counter width must match the register width");
        end
    endgenerate

    // Power-on counter must reach its last value without wrapping
    generate
        if (`TMR_POR_CYCLES > (1 << `TMR_POR_CNT_W)) begin : g_bad_por
            $error("tmr_top: power-on count does not fit its counter");
        end
    endgenerate

    localparam logic [`TMR_ADDR_W-1:0] CSR_ADDR = {`TMR_CSR_INDEX, 2'b00};
    localparam logic [`TMR_ADDR_W-1:0] CNT_ADDR = {`TMR_CNT_INDEX, 2'b00};
    localparam logic [`TMR_POR_CNT_W-1:0] POR_LAST =
        `TMR_POR_CNT_W'(`TMR_POR_CYCLES - 1);

    // ======================================================
    // State
    tmr_seq_e                   seq_ff;
    tmr_seq_e                   nxt_seq;
    logic [`TMR_POR_CNT_W-1:0]  por_cnt_ff;
    logic                       clear_ff;
    logic                       run_ff;
    tmr_rate_t                  rate_ff;
    logic                       wrap_en_ff;
    logic                       tick_en_ff;
    logic                       wrap_flag_ff;
    logic                       tick_flag_ff;
    logic                       irq_ff;
    logic                       por_busy_ff;
    logic                       wait_ff;
    logic [31:0]                rdata_ff;

    tmr_chain_if #(.COUNT_W(COUNT_W)) u_chain_if ();

    tmr_chain #(
        .PRESC_W   (`TMR_PRESC_BITS),
        .COUNT_W   (COUNT_W),
        .TICK_BASE (`TMR_TICK_BASE)
    ) u_chain (
        .i_clock (i_clock),
        .i_rst   (i_rst),
        .u_if    (u_chain_if)
    );

    // ======================================================
    // Reset sequencer decode
    wire in_por    = (seq_ff == tmr_por_count);
    wire running   = (seq_ff == tmr_running);
    wire por_done  = in_por & (por_cnt_ff == POR_LAST);
    // External reset is ignored while power-on counting is under way
    wire ext_act   = ~in_por & i_ext_reset;
    wire regs_hold = ~running;

    wire [`TMR_POR_CNT_W-1:0] nxt_por_cnt =
        in_por ? por_cnt_ff + `TMR_POR_CNT_W'(1) : por_cnt_ff;

    always_comb begin
        nxt_seq = seq_ff;
        case (seq_ff)
            tmr_por_count: begin
                if (por_done) begin
                    nxt_seq = i_ext_reset ? tmr_ext_hold : tmr_running;
                end
            end
            tmr_ext_hold: begin
                if (!i_ext_reset) begin
                    nxt_seq = tmr_running;
                end
            end
            tmr_running: begin
                if (i_ext_reset) begin
                    nxt_seq = tmr_ext_hold;
                end
            end
            default: begin
                nxt_seq = tmr_por_count;
            end
        endcase
    end

    // Chain cleared at power-on end and while external reset is held
    wire nxt_clear = por_done | ext_act;
    wire nxt_run   = ~i_stop_mode;

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            seq_ff     <= tmr_por_count;
            por_cnt_ff <= '0;
        end else begin
            seq_ff     <= nxt_seq;
            por_cnt_ff <= nxt_por_cnt;
        end
    end

    // Chain is held clear through reset so power-on counting starts from zero
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            clear_ff <= 1'b1;
            run_ff   <= 1'b0;
        end else begin
            clear_ff <= nxt_clear;
            run_ff   <= nxt_run;
        end
    end

    assign u_chain_if.clear    = clear_ff;
    assign u_chain_if.run      = run_ff;
    assign u_chain_if.rate_sel = rate_ff;

    // ======================================================
    // Avalon-MM slave decode
    // One wait cycle per access: data is captured while waitrequest is
    // high and presented with it low, so the answer never races the counter.
    wire req      = i_avs_read | i_avs_write;
    wire commit   = req & ~wait_ff;
    wire nxt_wait = ~(req & wait_ff);
    wire hit_csr  = (i_avs_address == CSR_ADDR);
    wire hit_cnt  = (i_avs_address == CNT_ADDR);
    wire csr_wr   = commit & i_avs_write & hit_csr & i_avs_byteenable[0];

    wire wr_rate_lo  = i_avs_writedata[`TMR_BIT_RATE_LO];
    wire wr_rate_hi  = i_avs_writedata[`TMR_BIT_RATE_HI];
    wire wr_tick_ack = i_avs_writedata[`TMR_BIT_TICK_ACK];
    wire wr_wrap_ack = i_avs_writedata[`TMR_BIT_WRAP_ACK];
    wire wr_tick_en  = i_avs_writedata[`TMR_BIT_TICK_EN];
    wire wr_wrap_en  = i_avs_writedata[`TMR_BIT_WRAP_EN];

    // ======================================================
    // Status view
    function automatic logic [7:0] csr_pack(input tmr_rate_t rate,
                                            input logic tick_en,
                                            input logic wrap_en,
                                            input logic tick_flag,
                                            input logic wrap_flag);
        logic [7:0] v;
        v                     = 8'h00;
        v[`TMR_BIT_RATE_LO]   = rate[0];
        v[`TMR_BIT_RATE_HI]   = rate[1];
        v[`TMR_BIT_TICK_ACK]  = 1'b0;
        v[`TMR_BIT_WRAP_ACK]  = 1'b0;
        v[`TMR_BIT_TICK_EN]   = tick_en;
        v[`TMR_BIT_WRAP_EN]   = wrap_en;
        v[`TMR_BIT_TICK_FLAG] = tick_flag;
        v[`TMR_BIT_WRAP_FLAG] = wrap_flag;
        return v;
    endfunction

    wire [7:0] csr_view = csr_pack(rate_ff, tick_en_ff, wrap_en_ff,
                                   tick_flag_ff, wrap_flag_ff);

    // Unmapped addresses read as zero and swallow writes
    wire [31:0] rd_word = hit_csr ? {24'h000000, csr_view} :
                          hit_cnt ? {24'h000000, u_chain_if.count} :
                                    32'h00000000;
    wire [31:0] nxt_rdata = (i_avs_read & wait_ff) ? rd_word : rdata_ff;

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            wait_ff <= 1'b1;
        end else begin
            wait_ff <= nxt_wait;
        end
    end

    // Read data is kept between reads, so a late sample still sees the last answer
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            rdata_ff <= 32'h00000000;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    // ======================================================
    // Control bits
    wire tmr_rate_t nxt_rate   = csr_wr ? {wr_rate_hi, wr_rate_lo} : rate_ff;
    wire            nxt_wrap_en = csr_wr ? wr_wrap_en : wrap_en_ff;
    wire            nxt_tick_en = csr_wr ? wr_tick_en : tick_en_ff;

    always_ff @(posedge i_clock) begin
        if (i_rst || regs_hold) begin
            rate_ff <= `TMR_RATE_RESET;
        end else begin
            rate_ff <= nxt_rate;
        end
    end

    // Writes made during power-on or external reset are dropped, not deferred
    always_ff @(posedge i_clock) begin
        if (i_rst || regs_hold) begin
            wrap_en_ff <= `TMR_EN_RESET;
        end else begin
            wrap_en_ff <= nxt_wrap_en;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst || regs_hold) begin
            tick_en_ff <= `TMR_EN_RESET;
        end else begin
            tick_en_ff <= nxt_tick_en;
        end
    end

    // ======================================================
    // Event flags: a new event outranks a same-cycle acknowledge
    wire wrap_clr = csr_wr & wr_wrap_ack;
    wire tick_clr = csr_wr & wr_tick_ack;
    wire nxt_wrap_flag = u_chain_if.wrap_evt | (wrap_flag_ff & ~wrap_clr);
    wire nxt_tick_flag = u_chain_if.tick_evt | (tick_flag_ff & ~tick_clr);

    always_ff @(posedge i_clock) begin
        if (i_rst || regs_hold) begin
            wrap_flag_ff <= `TMR_FLAG_RESET;
        end else begin
            wrap_flag_ff <= nxt_wrap_flag;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst || regs_hold) begin
            tick_flag_ff <= `TMR_FLAG_RESET;
        end else begin
            tick_flag_ff <= nxt_tick_flag;
        end
    end

    // ======================================================
    // Interrupt request and outputs
    wire wrap_req = wrap_flag_ff & wrap_en_ff;
    wire tick_req = tick_flag_ff & tick_en_ff;
    wire nxt_irq  = ~regs_hold & (wrap_req | tick_req);
    wire nxt_por_busy = (nxt_seq == tmr_por_count);

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= nxt_irq;
        end
    end

    // Busy follows the next state, so it falls on the edge of the second chain clear
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            por_busy_ff <= 1'b1;
        end else begin
            por_busy_ff <= nxt_por_busy;
        end
    end

    assign o_avs_readdata    = rdata_ff;
    assign o_avs_waitrequest = wait_ff;
    assign o_irq             = irq_ff;
    assign o_por_busy        = por_busy_ff;

endmodule

// [tmr_top_props.sv]
`timescale 1ns/1ps

// ==========================================================
// Port checks for the timer block
module tmr_top_props (
    input wire logic        i_clock,
    input wire logic        i_rst,
    input wire logic        i_ext_reset,
    input wire logic        i_stop_mode,
    input wire logic [7:0]  i_avs_address,
    input wire logic        i_avs_read,
    input wire logic        i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0]  i_avs_byteenable,
    input wire logic [31:0] o_avs_readdata,
    input wire logic        o_avs_waitrequest,
    input wire logic        o_irq,
    input wire logic        o_por_busy
);
    logic [12:0] por_len_ff;
    logic [12:0] nxt_por_len;
    logic        rd_ack;

    // Counts power-on cycles; wide enough that a stuck busy line shows up
    assign nxt_por_len = o_por_busy ? por_len_ff + 13'h1 : por_len_ff;
    assign rd_ack      = i_avs_read && !o_avs_waitrequest;

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            por_len_ff <= 13'h0;
        end else begin
            por_len_ff <= nxt_por_len;
        end
    end

    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (i_rst);

    // ==========================================================
    // Bus handshake
    sequence s_req_seen;
        (i_avs_read || i_avs_write) && o_avs_waitrequest;
    endsequence
    sequence s_one_wait;
        !o_avs_waitrequest ##1 o_avs_waitrequest;
    endsequence

    a_bus_one_wait: assert property (s_req_seen |=> s_one_wait)
        else $error("bus answer is not a single low cycle of waitrequest");
    a_idle_wait_high: assert property (!i_avs_read && !i_avs_write |=> o_avs_waitrequest)
        else $error("waitrequest low without a request");
    a_upper_zero: assert property (o_avs_readdata[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    a_ack_bits_zero: assert property (rd_ack && i_avs_address == 8'h20 |->
        o_avs_readdata[3:2] == 2'h0)
        else $error("acknowledge bits read back as one");
    a_unmapped_zero: assert property (rd_ack && i_avs_address == 8'h40 |-> o_avs_readdata == 32'h0)
        else $error("unmapped read not zero");

    // ==========================================================
    // Reset, power-on and stop
    a_reset_state: assert property ($fell(i_rst) |-> !o_irq && o_por_busy)
        else $error("wrong output state after reset");
    a_por_length: assert property ($fell(o_por_busy) |->
        por_len_ff inside {[13'hfde:13'hfe4]})
        else $error("power-on count length wrong");
    a_ext_irq_off: assert property (i_ext_reset [*2] |=> !o_irq)
        else $error("interrupt during external reset");
    a_stop_irq_hold: assert property (
        (i_stop_mode && !i_avs_write && !i_ext_reset) [*8] |-> $stable(o_irq))
        else $error("interrupt changed in stop mode");
endmodule

bind tmr_top tmr_top_props u_props (.i_clock(i_clock), .i_rst(i_rst), .i_ext_reset(i_ext_reset),
    .i_stop_mode(i_stop_mode), .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
    .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
    .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest), .o_irq(o_irq), .o_por_busy(o_por_busy));

// [tb_tmr_top.sv]
`timescale 1ns/1ps

module tb_tmr_top;
    logic        i_clock;
    logic        i_rst;
    logic        i_ext_reset;
    logic        i_stop_mode;
    logic [7:0]  i_avs_address;
    logic        i_avs_read;
    logic        i_avs_write;
    logic [31:0] i_avs_writedata;
    logic [3:0]  i_avs_byteenable;
    logic [31:0] o_avs_readdata;
    logic        o_avs_waitrequest;
    logic        o_irq;
    logic        o_por_busy;
    int          fails = 0;
    int          checks = 0;
    int          cyc = 0;
    int          t_bus;
    int          t_a;
    int          t_b;
    int          off [3];
    logic [7:0]  v_a;
    logic [7:0]  v_b;

    tmr_top dut (.i_clock(i_clock), .i_rst(i_rst), .i_ext_reset(i_ext_reset),
        .i_stop_mode(i_stop_mode), .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
        .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
        .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
        .o_avs_waitrequest(o_avs_waitrequest), .o_irq(o_irq), .o_por_busy(o_por_busy));

    initial i_clock = 1'b0;
    always #5 i_clock = ~i_clock;
    always @(posedge i_clock) cyc <= cyc + 1;

    // ==========================================================
    // Reporting
    task automatic results();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic check_val(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: register %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_bit(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: status line %b expected %b", $time, got, exp);
        end
    endtask

    task automatic check_cyc(input int got, input int exp);
        checks++;
        if (got != exp) begin
            fails++;
            $display("wrong value at %0t: span %0d expected %0d", $time, got, exp);
        end
    endtask

    // ==========================================================
    // Bus access; an extra edge after release keeps back-to-back calls race free
    task automatic bus(input logic wr, input logic [7:0] addr, input logic [7:0] wdata,
                       input logic [3:0] be, output logic [7:0] rdata);
        int n;
        n = 0;
        i_avs_address    <= addr;
        i_avs_writedata  <= {24'h0, wdata};
        i_avs_byteenable <= be;
        i_avs_read       <= !wr;
        i_avs_write      <= wr;
        @(posedge i_clock);
        while (o_avs_waitrequest !== 1'b0 && n < 20) begin
            n++;
            @(posedge i_clock);
        end
        if (n == 20) begin
            fails++;
            $display("wrong value at %0t: bus access never answered", $time);
        end
        rdata = o_avs_readdata[7:0];
        t_bus = cyc;
        i_avs_read  <= 1'b0;
        i_avs_write <= 1'b0;
        @(posedge i_clock);
    endtask

    task automatic wr(input logic [7:0] addr, input logic [7:0] data, input logic [3:0] be = 4'hf);
        logic [7:0] unused;
        bus(1'b1, addr, data, be, unused);
    endtask

    task automatic rd(input logic [7:0] addr, output logic [7:0] data);
        bus(1'b0, addr, 8'h00, 4'hf, data);
    endtask

    task automatic wait_irq(output int t);
        int n;
        n = 0;
        while (o_irq !== 1'b1 && n < 40000) begin
            n++;
            @(posedge i_clock);
        end
        if (n == 40000) begin
            fails++;
            $display("wrong value at %0t: interrupt never came", $time);
        end
        t = cyc;
    endtask

    // ==========================================================
    // Watchdog: the whole sequence needs about 65000 cycles
    initial begin
        repeat (80000) @(posedge i_clock);
        fails++;
        $display("wrong value at %0t: run did not finish in time", $time);
        results();
    end

    // ==========================================================
    // Test sequence
    initial begin
        i_rst = 1'b1;
        i_ext_reset = 1'b0;
        i_stop_mode = 1'b0;
        i_avs_address = 8'h00;
        i_avs_read = 1'b0;
        i_avs_write = 1'b0;
        i_avs_writedata = 32'h0;
        i_avs_byteenable = 4'h0;
        repeat (16) @(posedge i_clock);
        i_rst <= 1'b0;
        t_a = 0;
        while (o_por_busy !== 1'b0 && t_a < 5000) begin
            t_a++;
            @(posedge i_clock);
        end
        check_bit(o_por_busy, 1'b0);
        rd(8'h20, v_a);
        check_val(v_a, 8'h03);
        rd(8'h40, v_a);
        check_val(v_a, 8'h00);
        rd(8'h24, v_a);
        t_a = t_bus;
        wr(8'h24, 8'h00);
        repeat (390) @(posedge i_clock);
        rd(8'h24, v_b);
        check_val(v_b, v_a + 8'((t_bus - t_a) / 4));
        wr(8'h20, 8'h23, 4'h0);
        rd(8'h20, v_a);
        check_val(v_a, 8'h03);
        wr(8'h20, 8'h23);
        wait_irq(t_a);
        rd(8'h20, v_a);
        check_val(v_a, 8'ha3);
        wr(8'h20, 8'h2b);
        repeat (2) @(posedge i_clock);
        check_bit(o_irq, 1'b0);
        wait_irq(t_b);
        check_cyc(t_b - t_a, 1024);
        wr(8'h20, 8'h0b);
        rd(8'h20, v_a);
        check_val(v_a, 8'h03);
        i_stop_mode <= 1'b1;
        repeat (4) @(posedge i_clock);
        rd(8'h24, v_a);
        repeat (100) @(posedge i_clock);
        rd(8'h24, v_b);
        check_val(v_b, v_a);
        i_stop_mode <= 1'b0;
        // Rates 0 to 2 are each timed from a fresh chain clear so the offsets compare directly
        for (int r = 0; r < 3; r++) begin
            i_ext_reset <= 1'b1;
            repeat (4) @(posedge i_clock);
            i_ext_reset <= 1'b0;
            @(posedge i_clock);
            t_a = cyc;
            rd(8'h24, v_a);
            check_val(v_a, 8'h00);
            rd(8'h20, v_a);
            check_val(v_a, 8'h03);
            wr(8'h20, 8'h10 | 8'(r));
            wait_irq(t_b);
            off[r] = t_b - t_a;
            rd(8'h20, v_a);
            check_val(v_a, 8'hd0 | 8'(r));
            wr(8'h20, 8'h14 | 8'(r));
            repeat (2) @(posedge i_clock);
            check_bit(o_irq, 1'b0);
        end
        check_cyc(off[1] - off[0], 8192);
        check_cyc(off[2] - off[0], 24576);
        results();
    end
endmodule
